/* File: common/nvac_consts.svh */
// Constants of the nonvolatile memory access controller.
// Assumes one 10 MHz clock and software access over APB.
// Functional notes
// - Data EEPROM read result lands in low data register by next instruction cycle.
// - Read results hold until another read or a software data write.
// - Byte write starts only after 55h then AAh to unlock port, then write strobe.
// - Write strobe cannot be set unless write permit is already set.
// - A started write completes even if write permit is cleared meanwhile.
// - Hardware never clears write permit; only software changes it.
// - Write completion clears the write strobe and sets the write-done flag.
// - Write-done flag stays set until software clears it.
// - Flash read uses second instruction cycle; instruction in that slot is ignored.
// - Flash word is split across low and high data registers and held.
// - Unlock port stores nothing and reads as zero.
// - Software may only set the write strobe; hardware clears it.
// - Write-abort flag is set when an external reset cuts a write short.
// - Memory select is zero after power-on and frozen while writing.
`ifndef NVAC_CONSTS_SVH
`define NVAC_CONSTS_SVH
`define NVAC_OFS_ADDR_LOW 12'h000
`define NVAC_OFS_ADDR_HIGH 12'h004
`define NVAC_OFS_DATA_LOW 12'h008
`define NVAC_OFS_DATA_HIGH 12'h00C
`define NVAC_OFS_CONTROL 12'h010
`define NVAC_OFS_UNLOCK 12'h014
`define NVAC_OFS_FLAGS 12'h018
`define NVAC_BIT_MSEL 7
`define NVAC_BIT_ABORT 3
`define NVAC_BIT_PERMIT 2
`define NVAC_BIT_WR 1
`define NVAC_BIT_RD 0
`define NVAC_BIT_DONE 0
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'hAA
`define NVAC_RST_BYTE 8'h00
`define NVAC_CLK_MHZ 10
`define NVAC_T_PROG_US 2000
`define NVAC_CYC_DIV 2'h3
`endif

/* File: common/nvac_pkg.sv */
// Types of the nonvolatile memory access controller.
// Assumes nvac_consts.svh sits in the include path.
package nvac_pkg;
  typedef enum logic [1:0] {
    NVAC_IDLE = 2'b00,
    NVAC_EE_RD = 2'b01,
    NVAC_FL_RD = 2'b11,
    NVAC_WRITE = 2'b10
  } nvac_state_e;
  typedef enum logic [1:0] {
    NVAC_LOCKED = 2'b00,
    NVAC_KEY1 = 2'b01,
    NVAC_ARMED = 2'b11
  } nvac_unlock_e;
  typedef struct packed {
    logic memory_select;
    logic write_abort_flag;
    logic write_permit;
    logic write_strobe;
    logic read_strobe;
  } nvac_ctrl_s;
endpackage

/* File: verif/nvac_checker.sv */
// Port checker of the nonvolatile memory access controller.
// Assumes it is bound into nvac_top and sees only that module's ports.
`timescale 1ns/1ns
module nvac_checker #(
  parameter int PROG_CYC = 20
) (
  // Clock and resets
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic EXT_RST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Flash port and status
  input wire logic FLASH_RD,
  input wire logic IGNORE_SLOT,
  input wire logic WRITE_DONE_FLAG,
  input wire logic WRITE_ACTIVE
);
  int cnt_q;
  wire clr_done = PREADY && PWRITE && PADDR == 12'h018;
  wire ctl_wr = PREADY && PWRITE && PADDR == 12'h010;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // Counting the strobe lets the programming time be held to within one clock of its length.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) cnt_q <= 0;
    else cnt_q <= WRITE_ACTIVE ? cnt_q + 1 : 0;
  end
  a_ready_late: assert property (PSEL && PENABLE && !$past(PENABLE) |=> PREADY)
    else $error("ready missing in second access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
  a_bus_quiet: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("bus outputs not quiet");
  a_slverr_map: assert property (PREADY && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > 12'h018))
    else $error("slave error wrong");
  a_flash_window: assert property ($rose(FLASH_RD) |-> FLASH_RD [*4] ##1 !FLASH_RD)
    else $error("flash window not four clocks");
  a_slot_match: assert property (IGNORE_SLOT == FLASH_RD) else $error("slot mismatch");
  a_prog_time: assert property ($fell(WRITE_ACTIVE) && $past(EXT_RST_N) |->
    cnt_q >= PROG_CYC - 1 && cnt_q <= PROG_CYC + 1) else $error("programming time wrong");
  a_done_set: assert property ($fell(WRITE_ACTIVE) && $past(EXT_RST_N) |-> WRITE_DONE_FLAG)
    else $error("done flag not set");
  a_done_hold: assert property (WRITE_DONE_FLAG && !clr_done |=> WRITE_DONE_FLAG)
    else $error("done flag lost");
  a_start_cause: assert property ($rose(WRITE_ACTIVE) |-> $past(ctl_wr))
    else $error("write began without control write");
  a_abort_quiet: assert property ($fell(WRITE_ACTIVE) && !$past(EXT_RST_N) |->
    !$rose(WRITE_DONE_FLAG)) else $error("aborted write flagged done");
  cover property ($fell(WRITE_ACTIVE) && $past(EXT_RST_N));
  cover property ($fell(WRITE_ACTIVE) && !$past(EXT_RST_N));
  cover property ($rose(FLASH_RD));
endmodule

/* File: verif/nvac_flash_model.sv */
// Flash program array model answering the controller's word reads.
// Assumes the controller holds the address while its read strobe stands.
`timescale 1ns/1ns
module nvac_flash_model (
  // Read port
  input wire logic rd,
  input wire logic [10:0] addr,
  output logic [13:0] word
);
  // Outside a read the word is inverted, so an early or late capture cannot match.
  assign word = rd ? {addr, 3'h5} : ~{addr, 3'h5};
endmodule

/* File: verif/nvac_top_tb.sv */
// Self-checking bench of the nonvolatile memory access controller.
// Assumes the flash model on the far side and the checker bound to the top.
`timescale 1ns/1ns
module nvac_top_tb;
  localparam int PROG_CYC = 20;
  logic REF_CLK, RSTN, EXT_RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic FLASH_RD, IGNORE_SLOT, WRITE_DONE_FLAG, WRITE_ACTIVE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rnd;
  logic [10:0] FLASH_ADDR;
  logic [13:0] FLASH_WORD;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [7:0] lo;
  int n_fail = 0, checked = 0, cyc = 0;
  nvac_top #(.PROG_CYC(PROG_CYC)) DUT (.*);
  nvac_flash_model flash (.rd(FLASH_RD), .addr(FLASH_ADDR), .word(FLASH_WORD));
  initial begin
    REF_CLK = 1'h0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The note x holds {compare data, slave error, data}.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [33:0] x);
    q.push_back(x);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    @(posedge REF_CLK iff PREADY === 1'h1);
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 34'h0);
  endtask
  task automatic r(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0, {2'h2, x});
  endtask
  task automatic idle(input int n);
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    repeat (n) @(posedge REF_CLK);
  endtask
  // No interrupt can split the key writes here, as the bench issues them back to back.
  task automatic start_write(input logic [7:0] a, input logic [7:0] d);
    w(12'h000, {24'h0, a});
    w(12'h008, {24'h0, d});
    w(12'h010, 32'h4);
    w(12'h014, 32'h55);
    w(12'h014, 32'hAA);
    w(12'h010, 32'h6);
  endtask
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'h1 && q.size() > 0) begin
      e = q.pop_front();
      check($sformatf("apb at %h", PADDR), {PSLVERR, PRDATA & {32{e[33]}}}, e[32:0]);
    end
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    {RSTN, EXT_RST_N, PSEL, PENABLE, PWRITE} = 5'h08;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    rnd = 32'h00012641;
    repeat (5) @(posedge REF_CLK);
    RSTN <= 1'h1;
    @(posedge REF_CLK);
    for (int a = 0; a < 8; a++)
      apb(1'h0, 12'(a * 4), 32'h0, {1'h1, a == 7, 32'h0});
    apb(1'h1, 12'h01C, rnd, {2'h1, 32'h0});
    for (int a = 0; a < 4; a++) begin
      rnd = lfsr(rnd);
      w(12'(a * 4), rnd);
      r(12'(a * 4), rnd & (a == 3 ? 32'h3F : 32'hFF));
    end
    w(12'h010, 32'h4);
    w(12'h014, 32'hAA);
    w(12'h014, 32'h55);
    w(12'h010, 32'h6);
    r(12'h010, 32'h4);
    w(12'h014, 32'h55);
    w(12'h000, 32'h21);
    w(12'h014, 32'hAA);
    w(12'h010, 32'h6);
    r(12'h010, 32'h4);
    w(12'h010, 32'h0);
    w(12'h014, 32'h55);
    w(12'h014, 32'hAA);
    w(12'h010, 32'h2);
    r(12'h010, 32'h0);
    rnd = lfsr(rnd);
    lo = rnd[7:0];
    start_write(8'h21, lo);
    w(12'h010, 32'h80);
    r(12'h010, 32'h2);
    idle(1);
    while (WRITE_ACTIVE !== 1'h0) @(posedge REF_CLK);
    check("done pin", {32'h0, WRITE_DONE_FLAG}, 33'h1);
    r(12'h018, 32'h1);
    r(12'h010, 32'h0);
    w(12'h018, 32'h0);
    r(12'h018, 32'h0);
    w(12'h008, {24'h0, ~lo});
    w(12'h010, 32'h1);
    idle(5);
    r(12'h008, {24'h0, lo});
    start_write(8'h22, 8'h5A);
    idle(3);
    EXT_RST_N <= 1'h0;
    repeat (2) @(posedge REF_CLK);
    EXT_RST_N <= 1'h1;
    r(12'h010, 32'hC);
    r(12'h018, 32'h0);
    rnd = lfsr(rnd);
    lo = rnd[7:0];
    w(12'h004, 32'h5);
    w(12'h000, {24'h0, lo});
    w(12'h010, 32'h80);
    w(12'h010, 32'h81);
    idle(1);
    while (FLASH_RD !== 1'h1) @(posedge REF_CLK);
    check("flash addr", {22'h0, FLASH_ADDR}, {22'h0, 3'h5, lo});
    check("ignore slot", {32'h0, IGNORE_SLOT}, 33'h1);
    while (FLASH_RD !== 1'h0) @(posedge REF_CLK);
    r(12'h008, {24'h0, lo[4:0], 3'h5});
    r(12'h00C, {26'h0, 3'h5, lo[7:5]});
    idle(2);
    report_and_stop;
  end
endmodule
bind nvac_top nvac_checker #(.PROG_CYC(PROG_CYC)) u_chk (.*);

/* File: verilog/nvac_top.sv */
// Nonvolatile memory access controller: data EEPROM byte access and
// flash word reads, reached by software over APB.
// Assumes the flash array sits outside and answers a read in the same cycle.
`timescale 1ns/1ns
`include "nvac_consts.svh"
module nvac_top #(
  parameter int PROG_CYC = `NVAC_T_PROG_US * `NVAC_CLK_MHZ
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // External or watchdog reset of the core, active low
  input wire logic EXT_RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Flash program memory read port
  output logic FLASH_RD,
  output logic [10:0] FLASH_ADDR,
  input wire logic [13:0] FLASH_WORD,
  // Core status
  output logic IGNORE_SLOT,
  output logic WRITE_DONE_FLAG,
  output logic WRITE_ACTIVE
);
  import nvac_pkg::*;

  logic [1:0] div_q;
  logic cyc_en;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] addr_low_q;
  logic [7:0] addr_high_q;
  logic [7:0] data_low_q;
  logic [5:0] data_high_q;
  nvac_ctrl_s ctrl_q;
  nvac_state_e state_q;
  nvac_unlock_e unlock_q;
  logic done_q;
  logic fl_step_q;
  logic flash_rd_q;
  logic ignore_q;
  logic [10:0] flash_addr_q;
  logic [31:0] prog_cnt_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] ee_mem [0:255];
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic start_wr;
  logic start_rd;
  logic prog_end;
  logic ext_abort;
  logic ee_rd_fin;
  logic fl_rd_fin;

  // The access phase lasts two cycles so read data can come from a flop.
  assign wr_acc = PSEL && PENABLE && pready_q && PWRITE;
  assign rd_acc = PSEL && PENABLE && !pready_q && !PWRITE;
  assign mapped = (PADDR == `NVAC_OFS_ADDR_LOW) || (PADDR == `NVAC_OFS_ADDR_HIGH)
    || (PADDR == `NVAC_OFS_DATA_LOW) || (PADDR == `NVAC_OFS_DATA_HIGH)
    || (PADDR == `NVAC_OFS_CONTROL) || (PADDR == `NVAC_OFS_UNLOCK)
    || (PADDR == `NVAC_OFS_FLAGS);
  assign cyc_en = (div_q == `NVAC_CYC_DIV);

  assign start_wr = wr_acc && (PADDR == `NVAC_OFS_CONTROL) && PWDATA[`NVAC_BIT_WR]
    && ctrl_q.write_permit && (unlock_q == NVAC_ARMED)
    && (state_q == NVAC_IDLE) && EXT_RST_N;
  assign start_rd = wr_acc && (PADDR == `NVAC_OFS_CONTROL) && PWDATA[`NVAC_BIT_RD]
    && !start_wr && (state_q == NVAC_IDLE) && EXT_RST_N;
  assign prog_end = (state_q == NVAC_WRITE) && (prog_cnt_q == 32'h0000_0001);
  assign ext_abort = !EXT_RST_N && (state_q == NVAC_WRITE);
  assign ee_rd_fin = (state_q == NVAC_EE_RD) && cyc_en;
  assign fl_rd_fin = (state_q == NVAC_FL_RD) && cyc_en && fl_step_q;

  // Instruction cycle is four clocks; cyc_en marks its end.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= PSEL && PENABLE && !pready_q;
      pslverr_q <= PSEL && PENABLE && !pready_q && !mapped;
      if (rd_acc) begin
        case (PADDR)
          `NVAC_OFS_ADDR_LOW: prdata_q <= {24'h000000, addr_low_q};
          `NVAC_OFS_ADDR_HIGH: prdata_q <= {24'h000000, addr_high_q};
          `NVAC_OFS_DATA_LOW: prdata_q <= {24'h000000, data_low_q};
          `NVAC_OFS_DATA_HIGH: prdata_q <= {26'h0000000, data_high_q};
          `NVAC_OFS_CONTROL: prdata_q <= {24'h000000, ctrl_q.memory_select, 3'h0,
            ctrl_q.write_abort_flag, ctrl_q.write_permit, ctrl_q.write_strobe,
            ctrl_q.read_strobe};
          `NVAC_OFS_FLAGS: prdata_q <= {31'h00000000, done_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Any write that breaks the key order drops back to locked, and
  // every started byte consumes the keys.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      unlock_q <= NVAC_LOCKED;
    end else if (wr_acc) begin
      if (PADDR == `NVAC_OFS_UNLOCK && PWDATA[7:0] == `NVAC_KEY_FIRST) begin
        unlock_q <= NVAC_KEY1;
      end else if (PADDR == `NVAC_OFS_UNLOCK && PWDATA[7:0] == `NVAC_KEY_SECOND
          && unlock_q == NVAC_KEY1) begin
        unlock_q <= NVAC_ARMED;
      end else begin
        unlock_q <= NVAC_LOCKED;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_low_q <= `NVAC_RST_BYTE;
      addr_high_q <= `NVAC_RST_BYTE;
    end else if (wr_acc && PADDR == `NVAC_OFS_ADDR_LOW) begin
      addr_low_q <= PWDATA[7:0];
    end else if (wr_acc && PADDR == `NVAC_OFS_ADDR_HIGH) begin
      addr_high_q <= PWDATA[7:0];
    end
  end

  // A finishing read wins over a software write in the same cycle.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      data_low_q <= `NVAC_RST_BYTE;
      data_high_q <= 6'h00;
    end else if (ee_rd_fin) begin
      data_low_q <= ee_mem[addr_low_q];
    end else if (fl_rd_fin) begin
      data_low_q <= FLASH_WORD[7:0];
      data_high_q <= FLASH_WORD[13:8];
    end else if (wr_acc && PADDR == `NVAC_OFS_DATA_LOW) begin
      data_low_q <= PWDATA[7:0];
    end else if (wr_acc && PADDR == `NVAC_OFS_DATA_HIGH) begin
      data_high_q <= PWDATA[5:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= '0;
    end else begin
      if (wr_acc && PADDR == `NVAC_OFS_CONTROL) begin
        ctrl_q.write_permit <= PWDATA[`NVAC_BIT_PERMIT];
        ctrl_q.write_abort_flag <= PWDATA[`NVAC_BIT_ABORT];
        if (state_q != NVAC_WRITE) begin
          ctrl_q.memory_select <= PWDATA[`NVAC_BIT_MSEL];
        end
      end
      // Strobes are set only by software and cleared only here.
      if (start_wr) begin
        ctrl_q.write_strobe <= 1'b1;
      end else if (prog_end || ext_abort) begin
        ctrl_q.write_strobe <= 1'b0;
      end
      if (start_rd) begin
        ctrl_q.read_strobe <= 1'b1;
      end else if (ee_rd_fin || fl_rd_fin) begin
        ctrl_q.read_strobe <= 1'b0;
      end
      if (ext_abort) begin
        ctrl_q.write_abort_flag <= 1'b1;
      end
    end
  end

  // Flash read: the strobe write ends instruction cycle 0; the port reads in
  // cycle 1, and the instruction executing in that slot is flagged ignored.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= NVAC_IDLE;
      fl_step_q <= 1'b0;
      flash_rd_q <= 1'b0;
      ignore_q <= 1'b0;
      flash_addr_q <= 11'h000;
      prog_cnt_q <= 32'h0000_0000;
      wr_addr_q <= `NVAC_RST_BYTE;
      wr_data_q <= `NVAC_RST_BYTE;
    end else begin
      case (state_q)
        NVAC_IDLE: begin
          if (start_wr) begin
            state_q <= NVAC_WRITE;
            prog_cnt_q <= PROG_CYC;
            wr_addr_q <= addr_low_q;
            wr_data_q <= data_low_q;
          end else if (start_rd && ctrl_q.memory_select) begin
            state_q <= NVAC_FL_RD;
            fl_step_q <= 1'b0;
            flash_addr_q <= {addr_high_q[2:0], addr_low_q};
          end else if (start_rd) begin
            state_q <= NVAC_EE_RD;
          end
        end
        NVAC_EE_RD: begin
          if (cyc_en) begin
            state_q <= NVAC_IDLE;
          end
        end
        NVAC_FL_RD: begin
          if (cyc_en && !fl_step_q) begin
            fl_step_q <= 1'b1;
            flash_rd_q <= 1'b1;
            ignore_q <= 1'b1;
          end else if (cyc_en) begin
            state_q <= NVAC_IDLE;
            fl_step_q <= 1'b0;
            flash_rd_q <= 1'b0;
            ignore_q <= 1'b0;
          end
        end
        NVAC_WRITE: begin
          // Write permit is not looked at here, so clearing it cannot stop us.
          if (!EXT_RST_N || prog_end) begin
            state_q <= NVAC_IDLE;
            prog_cnt_q <= 32'h0000_0000;
          end else begin
            prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
          end
        end
        default: state_q <= NVAC_IDLE;
      endcase
    end
  end

  // The cell is written only on a full programming time, so an aborted
  // write leaves the old byte in place.
  always_ff @(posedge REF_CLK) begin
    if (prog_end && EXT_RST_N) begin
      ee_mem[wr_addr_q] <= wr_data_q;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      done_q <= 1'b0;
    end else if (prog_end && EXT_RST_N) begin
      done_q <= 1'b1;
    end else if (wr_acc && PADDR == `NVAC_OFS_FLAGS) begin
      done_q <= PWDATA[`NVAC_BIT_DONE];
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign FLASH_RD = flash_rd_q;
  assign FLASH_ADDR = flash_addr_q;
  assign IGNORE_SLOT = ignore_q;
  assign WRITE_DONE_FLAG = done_q;
  assign WRITE_ACTIVE = ctrl_q.write_strobe;
endmodule
